// [rtl/fdm_exec_top.sv]
// flag and data move executor with an ahb-lite register port
// assumes memories and io answer on the same clock, see the data ports
`timescale 1ns/1ps
module fdm_exec_top (
	// clock and reset
	input  wire logic               ref_clk_in,
	input  wire logic               reset_n_in,
	// ahb-lite slave
	input  wire logic               hsel_in,
	input  wire logic [31:0]        haddr_in,
	input  wire logic [1:0]         htrans_in,
	input  wire logic               hwrite_in,
	input  wire logic [2:0]         hsize_in,
	input  wire logic [31:0]        hwdata_in,
	input  wire logic               hready_in,
	output logic [31:0]             hrdata_out,
	output logic                    hreadyout_out,
	output logic                    hresp_out,
	// data, code and io space
	output fdm_pkg::fdm_mem_req_s   dmem_req_out,
	input  wire logic [7:0]         dmem_rdata_in,
	output fdm_pkg::fdm_mem_req_s   pmem_req_out,
	input  wire logic [7:0]         pmem_rdata_in,
	output fdm_pkg::fdm_mem_req_s   io_req_out,
	input  wire logic [7:0]         io_rdata_in,
	// global interrupt enable
	output logic                    irq_enable_out
);

	// ********************************************************
	// declarations
	// ********************************************************
	fdm_pkg::fdm_state_e    state_q;
	fdm_pkg::fdm_dec_s      dec;
	fdm_pkg::fdm_dec_s      new_dec;
	fdm_pkg::fdm_mem_req_s  dmem_d;
	fdm_pkg::fdm_mem_req_s  pmem_d;
	logic [31:0]            cmd_q;
	logic [1:0]             ncyc;
	logic [1:0]             cyc_q;
	logic [1:0]             last_cyc_q;
	logic [7:0]             flag_q;
	logic [7:0]             flag_d;
	logic [15:0]            sp_q;
	logic [15:0]            sp_d;
	logic [31:0][7:0]       regs;
	logic                   acc;
	logic                   map;
	logic                   ap_wr_q;
	logic [7:0]             ap_addr_q;
	logic                   busy;
	logic                   start;
	logic                   bus_idle_wr;
	logic                   done;
	logic [31:0]            rd_mux;
	logic [15:0]            ptr_val;
	logic [1:0]             ptr_sel;
	logic [3:0]             pw_idx;
	logic [15:0]            ea;
	logic                   ex_wr_en;
	logic [4:0]             ex_wr_idx;
	logic [7:0]             ex_wr_data;
	logic                   pw_en;
	logic [15:0]            pw_data;
	logic                   rf_wr_en;
	logic [4:0]             rf_wr_idx;
	logic [7:0]             rf_wr_data;

	// ********************************************************
	// decode and registers
	// ********************************************************
	fdm_decode u_dec (
		.cmd_in   (cmd_q),
		.dec_out  (dec),
		.ncyc_out (ncyc)
	);

	fdm_decode u_dec_new (
		.cmd_in   (hwdata_in),
		.dec_out  (new_dec),
		.ncyc_out ()
	);

	fdm_regfile u_regs (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.wr_en_in   (rf_wr_en),
		.wr_idx_in  (rf_wr_idx),
		.wr_data_in (rf_wr_data),
		.pw_en_in   (pw_en),
		.pw_idx_in  (pw_idx),
		.pw_data_in (pw_data),
		.regs_out   (regs)
	);

	// ********************************************************
	// ahb-lite slave
	// ********************************************************
	// address phase decode, always zero wait
	assign acc  = hsel_in & htrans_in[1] & hready_in;
	assign map  = (haddr_in[31:8] == 24'h0) && (haddr_in[1:0] == 2'h0) &&
		(haddr_in[7] || haddr_in[7:0] <= fdm_pkg::OFS_SP);
	assign busy = (state_q != fdm_pkg::ST_IDLE);
	assign start = ap_wr_q && (ap_addr_q == fdm_pkg::OFS_CMD) && !busy;
	assign bus_idle_wr = ap_wr_q && !busy;

	// read mux for the address phase
	always_comb begin
		rd_mux = 32'h0;
		if (haddr_in[7]) begin
			rd_mux[7:0] = regs[haddr_in[6:2]];
		end else begin
			unique case (haddr_in[7:0])
				fdm_pkg::OFS_CMD:  rd_mux = cmd_q;
				fdm_pkg::OFS_FLAG: rd_mux[7:0] = flag_q;
				fdm_pkg::OFS_SP:   rd_mux[15:0] = sp_q;
				fdm_pkg::OFS_STAT: begin
					rd_mux[fdm_pkg::STAT_BUSY] = busy;
					rd_mux[fdm_pkg::STAT_CYC +: 2] = last_cyc_q;
				end
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// address phase capture and read data
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			ap_wr_q       <= 1'b0;
			ap_addr_q     <= 8'h00;
			hrdata_out    <= 32'h0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			ap_wr_q       <= acc && hwrite_in && map;
			ap_addr_q     <= haddr_in[7:0];
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			if (acc && !hwrite_in) begin
				hrdata_out <= map ? rd_mux : 32'h0;
			end
		end
	end

	// ********************************************************
	// execute sequencer
	// ********************************************************
	assign done = (state_q == fdm_pkg::ST_LAST) ||
		(state_q == fdm_pkg::ST_EXEC && ncyc == 2'h1);

	// command capture and state walk
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			state_q <= fdm_pkg::ST_IDLE;
			cmd_q   <= 32'h0;
		end else begin
			unique case (state_q)
				fdm_pkg::ST_IDLE: if (start) begin
					cmd_q   <= hwdata_in;
					state_q <= fdm_pkg::ST_EXEC;
				end
				fdm_pkg::ST_EXEC: state_q <= (ncyc == 2'h1) ? fdm_pkg::ST_IDLE :
					(ncyc == 2'h3) ? fdm_pkg::ST_WAIT : fdm_pkg::ST_LAST;
				fdm_pkg::ST_WAIT: state_q <= fdm_pkg::ST_LAST;
				fdm_pkg::ST_LAST: state_q <= fdm_pkg::ST_IDLE;
			endcase
		end
	end

	// cycle count of the running and last command
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			cyc_q      <= 2'h0;
			last_cyc_q <= 2'h0;
		end else begin
			cyc_q <= start ? 2'h1 : (busy ? 2'(cyc_q + 2'h1) : cyc_q);
			if (done) begin
				last_cyc_q <= cyc_q;
			end
		end
	end

	// ********************************************************
	// operation datapath
	// ********************************************************
	// pointer value and effective address, code space always through z
	assign ptr_sel = (dec.op == fdm_pkg::OP_CODE_RD || dec.op == fdm_pkg::OP_CODE_WR) ?
		fdm_pkg::PTR_Z : dec.ptr;
	assign ptr_val = {regs[{fdm_pkg::fdm_ptr_pair(ptr_sel), 1'b1}],
		regs[{fdm_pkg::fdm_ptr_pair(ptr_sel), 1'b0}]};

	// pair port target: destination pair for pair copy, else the pointer
	assign pw_idx = (dec.op == fdm_pkg::OP_PAIR_COPY) ? dec.rd[4:1] :
		fdm_pkg::fdm_ptr_pair(ptr_sel);

	always_comb begin
		unique case (dec.amode)
			fdm_pkg::AM_DEC:  ea = 16'(ptr_val - 16'h1);
			fdm_pkg::AM_DISP: ea = 16'(ptr_val + {10'h0, dec.k[5:0]});
			default:          ea = ptr_val;
		endcase
	end

	// per-op effects in execute and last cycle
	always_comb begin
		ex_wr_en   = 1'b0;
		ex_wr_idx  = dec.rd;
		ex_wr_data = 8'h00;
		pw_en      = 1'b0;
		pw_data    = 16'h0;
		flag_d     = flag_q;
		sp_d       = sp_q;
		dmem_d     = '0;
		pmem_d     = '0;
		if (state_q == fdm_pkg::ST_EXEC) begin
			unique case (dec.op)
				fdm_pkg::OP_FLAG_SET: flag_d[dec.k[2:0]] = 1'b1;
				fdm_pkg::OP_FLAG_CLR: flag_d[dec.k[2:0]] = 1'b0;
				fdm_pkg::OP_IRQ_EN:   flag_d[fdm_pkg::FLG_I] = 1'b1;
				fdm_pkg::OP_IRQ_DIS:  flag_d[fdm_pkg::FLG_I] = 1'b0;
				fdm_pkg::OP_B2F: flag_d[fdm_pkg::FLG_T] = regs[dec.rr][dec.k[2:0]];
				fdm_pkg::OP_F2B: begin
					ex_wr_en   = 1'b1;
					ex_wr_data = regs[dec.rd];
					ex_wr_data[dec.k[2:0]] = flag_q[fdm_pkg::FLG_T];
				end
				fdm_pkg::OP_REG_COPY: begin
					ex_wr_en   = 1'b1;
					ex_wr_data = regs[dec.rr];
				end
				fdm_pkg::OP_PAIR_COPY: begin
					pw_en   = 1'b1;
					pw_data = {regs[{dec.rr[4:1], 1'b1}], regs[{dec.rr[4:1], 1'b0}]};
				end
				fdm_pkg::OP_IMM: begin
					ex_wr_en   = 1'b1;
					ex_wr_data = dec.k[7:0];
				end
				fdm_pkg::OP_PORT_IN: begin
					ex_wr_en   = 1'b1;
					ex_wr_data = io_rdata_in;
				end
				fdm_pkg::OP_PTR_RD, fdm_pkg::OP_PTR_WR: begin
					dmem_d.addr  = ea;
					dmem_d.wdata = {8'h00, regs[dec.rd]};
					dmem_d.we    = (dec.op == fdm_pkg::OP_PTR_WR);
					dmem_d.re    = (dec.op == fdm_pkg::OP_PTR_RD);
					pw_en   = (dec.amode == fdm_pkg::AM_INC) || (dec.amode == fdm_pkg::AM_DEC);
					pw_data = (dec.amode == fdm_pkg::AM_INC) ? 16'(ptr_val + 16'h1) : ea;
				end
				fdm_pkg::OP_DIR_RD, fdm_pkg::OP_DIR_WR: begin
					dmem_d.addr  = dec.k;
					dmem_d.wdata = {8'h00, regs[dec.rd]};
					dmem_d.we    = (dec.op == fdm_pkg::OP_DIR_WR);
					dmem_d.re    = (dec.op == fdm_pkg::OP_DIR_RD);
				end
				fdm_pkg::OP_PUSH: begin
					dmem_d.addr  = sp_q;
					dmem_d.wdata = {8'h00, regs[dec.rd]};
					dmem_d.we    = 1'b1;
					sp_d         = 16'(sp_q - 16'h1);
				end
				fdm_pkg::OP_POP: begin
					sp_d        = 16'(sp_q + 16'h1);
					dmem_d.addr = sp_d;
					dmem_d.re   = 1'b1;
				end
				fdm_pkg::OP_CODE_RD: begin
					pmem_d.addr = ptr_val;
					pmem_d.re   = 1'b1;
					pw_en       = (dec.amode == fdm_pkg::AM_INC);
					pw_data     = 16'(ptr_val + 16'h1);
				end
				fdm_pkg::OP_CODE_WR: begin
					pmem_d.addr  = ptr_val;
					pmem_d.wdata = {regs[1], regs[0]};
					pmem_d.we    = 1'b1;
				end
				default: ;
			endcase
		end else if (state_q == fdm_pkg::ST_LAST) begin
			unique case (dec.op)
				fdm_pkg::OP_PTR_RD, fdm_pkg::OP_DIR_RD, fdm_pkg::OP_POP: begin
					ex_wr_en   = 1'b1;
					ex_wr_data = dmem_rdata_in;
				end
				fdm_pkg::OP_CODE_RD: begin
					ex_wr_en   = 1'b1;
					ex_wr_idx  = (dec.amode == fdm_pkg::AM_PLAIN) ? 5'h00 : dec.rd;
					ex_wr_data = pmem_rdata_in;
				end
				default: ;
			endcase
		end
	end

	// register file write select: the bus only while idle
	assign rf_wr_en   = ex_wr_en || (bus_idle_wr && ap_addr_q[7]);
	assign rf_wr_idx  = ex_wr_en ? ex_wr_idx : ap_addr_q[6:2];
	assign rf_wr_data = ex_wr_en ? ex_wr_data : hwdata_in[7:0];

	// flag word and stack pointer
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			flag_q <= fdm_pkg::FLAG_RST;
		end else if (bus_idle_wr && ap_addr_q == fdm_pkg::OFS_FLAG) begin
			flag_q <= hwdata_in[7:0];
		end else begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			sp_q <= fdm_pkg::SP_RST;
		end else if (bus_idle_wr && ap_addr_q == fdm_pkg::OFS_SP) begin
			sp_q <= hwdata_in[15:0];
		end else begin
			sp_q <= sp_d;
		end
	end

	// memory requests, one-cycle pulses
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			dmem_req_out <= '0;
			pmem_req_out <= '0;
		end else begin
			dmem_req_out <= dmem_d;
			pmem_req_out <= pmem_d;
		end
	end

	// io request raised at start so the byte moves in the execute cycle
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			io_req_out <= '0;
		end else begin
			io_req_out <= '0;
			if (start) begin
				io_req_out.addr  <= {10'h0, new_dec.k[5:0]};
				io_req_out.wdata <= {8'h00, regs[new_dec.rd]};
				io_req_out.we    <= (new_dec.op == fdm_pkg::OP_PORT_OUT);
				io_req_out.re    <= (new_dec.op == fdm_pkg::OP_PORT_IN);
			end
		end
	end

	assign irq_enable_out = flag_q[fdm_pkg::FLG_I];

	// ********************************************************
	// assertions
	// ********************************************************
	logic exe;
	assign exe = (state_q == fdm_pkg::ST_EXEC);

	property p_b2f;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && dec.op == fdm_pkg::OP_B2F |=> flag_q[6] == $past(regs[dec.rr][dec.k[2:0]])
			&& flag_q[5:0] == $past(flag_q[5:0]) && flag_q[7] == $past(flag_q[7]);
	endproperty
	a_b2f: assert property (p_b2f) else $error("bit copy to T wrong");

	property p_f2b;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && dec.op == fdm_pkg::OP_F2B |=> state_q == fdm_pkg::ST_IDLE
			&& regs[dec.rd][dec.k[2:0]] == $past(flag_q[6]) && $stable(flag_q);
	endproperty
	a_f2b: assert property (p_f2b) else $error("T copy to bit wrong");

	property p_flag1;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && (dec.op == fdm_pkg::OP_FLAG_SET || dec.op == fdm_pkg::OP_FLAG_CLR) |=>
			flag_q[dec.k[2:0]] == (dec.op == fdm_pkg::OP_FLAG_SET)
			&& $countones(flag_q ^ $past(flag_q)) <= 1 && !busy;
	endproperty
	a_flag1: assert property (p_flag1) else $error("flag set or clear wrong");

	property p_irq;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && (dec.op == fdm_pkg::OP_IRQ_EN || dec.op == fdm_pkg::OP_IRQ_DIS) |=>
			irq_enable_out == (dec.op == fdm_pkg::OP_IRQ_EN) && !busy;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt enable flag wrong");

	property p_copy;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && dec.op == fdm_pkg::OP_REG_COPY |=>
			regs[dec.rd] == $past(regs[dec.rr]) && $stable(flag_q) && !busy;
	endproperty
	a_copy: assert property (p_copy) else $error("register copy wrong");

	property p_postinc;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && (dec.op == fdm_pkg::OP_PTR_RD || dec.op == fdm_pkg::OP_PTR_WR)
			&& dec.amode == fdm_pkg::AM_INC |=>
			dmem_req_out.addr == $past(ptr_val) && ptr_val == 16'($past(ptr_val) + 16'h1);
	endproperty
	a_postinc: assert property (p_postinc) else $error("post increment wrong");

	property p_predec;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && (dec.op == fdm_pkg::OP_PTR_RD || dec.op == fdm_pkg::OP_PTR_WR)
			&& dec.amode == fdm_pkg::AM_DEC |=>
			dmem_req_out.addr == ptr_val && ptr_val == 16'($past(ptr_val) - 16'h1);
	endproperty
	a_predec: assert property (p_predec) else $error("pre decrement wrong");

	property p_disp;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && dec.op == fdm_pkg::OP_PTR_RD && dec.amode == fdm_pkg::AM_DISP |=>
			dmem_req_out.addr == 16'($past(ptr_val) + {10'h0, dec.k[5:0]}) && $stable(ptr_val);
	endproperty
	a_disp: assert property (p_disp) else $error("displacement address wrong");

	property p_direct;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && (dec.op == fdm_pkg::OP_DIR_RD || dec.op == fdm_pkg::OP_DIR_WR) |=>
			dmem_req_out.addr == dec.k && (dmem_req_out.we ^ dmem_req_out.re) ##1 $stable(flag_q);
	endproperty
	a_direct: assert property (p_direct) else $error("direct address wrong");

	property p_two;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && ncyc == 2'h2 |=> state_q == fdm_pkg::ST_LAST ##1 state_q == fdm_pkg::ST_IDLE;
	endproperty
	a_two: assert property (p_two) else $error("two cycle op length wrong");

	property p_code;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && dec.op == fdm_pkg::OP_CODE_RD |=> pmem_req_out.re && !pmem_req_out.we
			##1 state_q == fdm_pkg::ST_LAST ##1 !busy && last_cyc_q == 2'h3;
	endproperty
	a_code: assert property (p_code) else $error("code read length wrong");

	property p_pop;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		exe && dec.op == fdm_pkg::OP_POP |=>
			dmem_req_out.re && dmem_req_out.addr == sp_q && sp_q == 16'($past(sp_q) + 16'h1);
	endproperty
	a_pop: assert property (p_pop) else $error("pop address wrong");

	property p_port;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		start |=> exe && (io_req_out.we == (dec.op == fdm_pkg::OP_PORT_OUT)) ##1
			(dec.op != fdm_pkg::OP_PORT_IN || !busy);
	endproperty
	a_port: assert property (p_port) else $error("port transfer wrong");

endmodule : fdm_exec_top

// [rtl/fdm_pkg.sv]
// constants, command layout and carriers for the flag and data move executor
// assumes one 40 MHz clock and a partner that answers memory requests on the same clock
package fdm_pkg;

	// ********************************************************
	// register offsets, reset values
	// ********************************************************
	localparam logic [7:0]  OFS_CMD    = 8'h00;
	localparam logic [7:0]  OFS_FLAG   = 8'h04;
	localparam logic [7:0]  OFS_STAT   = 8'h08;
	localparam logic [7:0]  OFS_SP     = 8'h0c;
	localparam logic [7:0]  OFS_GPR    = 8'h80;
	localparam logic [7:0]  FLAG_RST   = 8'h00;
	localparam logic [15:0] SP_RST     = 16'h00ff;
	localparam int          STAT_BUSY  = 0;
	localparam int          STAT_CYC   = 8;

	// ********************************************************
	// flag word bit positions
	// ********************************************************
	localparam logic [2:0]  FLG_C = 3'h0;
	localparam logic [2:0]  FLG_Z = 3'h1;
	localparam logic [2:0]  FLG_N = 3'h2;
	localparam logic [2:0]  FLG_V = 3'h3;
	localparam logic [2:0]  FLG_S = 3'h4;
	localparam logic [2:0]  FLG_H = 3'h5;
	localparam logic [2:0]  FLG_T = 3'h6;
	localparam logic [2:0]  FLG_I = 3'h7;

	// ********************************************************
	// command word: op[31:27] rd[26:22] rr[21:17] k[15:0]
	// ********************************************************
	localparam int          CMD_OP  = 27;
	localparam int          CMD_RD  = 22;
	localparam int          CMD_RR  = 17;
	localparam logic [4:0]  OP_NOP       = 5'h00;
	localparam logic [4:0]  OP_FLAG_SET  = 5'h01;
	localparam logic [4:0]  OP_FLAG_CLR  = 5'h02;
	localparam logic [4:0]  OP_B2F       = 5'h03;
	localparam logic [4:0]  OP_F2B       = 5'h04;
	localparam logic [4:0]  OP_IRQ_EN    = 5'h05;
	localparam logic [4:0]  OP_IRQ_DIS   = 5'h06;
	localparam logic [4:0]  OP_REG_COPY  = 5'h07;
	localparam logic [4:0]  OP_PAIR_COPY = 5'h08;
	localparam logic [4:0]  OP_IMM       = 5'h09;
	localparam logic [4:0]  OP_PTR_RD    = 5'h0a;
	localparam logic [4:0]  OP_PTR_WR    = 5'h0b;
	localparam logic [4:0]  OP_DIR_RD    = 5'h0c;
	localparam logic [4:0]  OP_DIR_WR    = 5'h0d;
	localparam logic [4:0]  OP_CODE_RD   = 5'h0e;
	localparam logic [4:0]  OP_CODE_WR   = 5'h0f;
	localparam logic [4:0]  OP_PORT_IN   = 5'h10;
	localparam logic [4:0]  OP_PORT_OUT  = 5'h11;
	localparam logic [4:0]  OP_PUSH      = 5'h12;
	localparam logic [4:0]  OP_POP       = 5'h13;

	// pointer select and address mode, carried in rr[1:0] and rr[3:2]
	localparam logic [1:0]  PTR_X   = 2'h0;
	localparam logic [1:0]  PTR_Y   = 2'h1;
	localparam logic [1:0]  PTR_Z   = 2'h2;
	localparam logic [1:0]  AM_PLAIN = 2'h0;
	localparam logic [1:0]  AM_INC   = 2'h1;
	localparam logic [1:0]  AM_DEC   = 2'h2;
	localparam logic [1:0]  AM_DISP  = 2'h3;
	localparam logic [3:0]  PAIR_X   = 4'hd;

	typedef struct packed {
		logic [4:0]  op;
		logic [4:0]  rd;
		logic [4:0]  rr;
		logic [1:0]  ptr;
		logic [1:0]  amode;
		logic [15:0] k;
	} fdm_dec_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        we;
		logic        re;
	} fdm_mem_req_s;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT, ST_LAST} fdm_state_e;

	// pair index of a pointer: x, y, z sit in the three top pairs
	function automatic logic [3:0] fdm_ptr_pair(input logic [1:0] ptr);
		fdm_ptr_pair = 4'(PAIR_X + {2'h0, ptr});
	endfunction : fdm_ptr_pair

endpackage : fdm_pkg

// [rtl/fdm_decode.sv]
// command word field split and cycle class
// assumes the command word layout of fdm_pkg
`timescale 1ns/1ps
module fdm_decode (
	// command in
	input  wire logic [31:0]      cmd_in,
	// fields out
	output fdm_pkg::fdm_dec_s     dec_out,
	output logic [1:0]            ncyc_out
);
	// field split
	always_comb begin
		dec_out.op    = cmd_in[fdm_pkg::CMD_OP +: 5];
		dec_out.rd    = cmd_in[fdm_pkg::CMD_RD +: 5];
		dec_out.rr    = cmd_in[fdm_pkg::CMD_RR +: 5];
		dec_out.ptr   = cmd_in[fdm_pkg::CMD_RR +: 2];
		dec_out.amode = cmd_in[fdm_pkg::CMD_RR + 2 +: 2];
		dec_out.k     = cmd_in[15:0];
	end

	// execute length in cycles
	always_comb begin
		unique case (cmd_in[fdm_pkg::CMD_OP +: 5])
			fdm_pkg::OP_PTR_RD, fdm_pkg::OP_PTR_WR, fdm_pkg::OP_DIR_RD,
			fdm_pkg::OP_DIR_WR, fdm_pkg::OP_CODE_WR, fdm_pkg::OP_PUSH,
			fdm_pkg::OP_POP:    ncyc_out = 2'h2;
			fdm_pkg::OP_CODE_RD: ncyc_out = 2'h3;
			default:            ncyc_out = 2'h1;
		endcase
	end
endmodule : fdm_decode

// [rtl/fdm_regfile.sv]
// thirty-two byte working registers with a byte port and a pair port
// assumes the two write ports are never aimed at the same cycle
`timescale 1ns/1ps
module fdm_regfile (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             reset_n_in,
	// byte write
	input  wire logic             wr_en_in,
	input  wire logic [4:0]       wr_idx_in,
	input  wire logic [7:0]       wr_data_in,
	// pair write
	input  wire logic             pw_en_in,
	input  wire logic [3:0]       pw_idx_in,
	input  wire logic [15:0]      pw_data_in,
	// all registers
	output logic [31:0][7:0]      regs_out
);
	// byte and pair updates
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			regs_out <= '0;
		end else if (pw_en_in) begin
			regs_out[{pw_idx_in, 1'b0}] <= pw_data_in[7:0];
			regs_out[{pw_idx_in, 1'b1}] <= pw_data_in[15:8];
		end else if (wr_en_in) begin
			regs_out[wr_idx_in] <= wr_data_in;
		end
	end
endmodule : fdm_regfile

// [test/fdm_partner.sv]
// partner: data, code and io space answering with fixed byte patterns
// assumes the executor's request timing, one shared clock
`timescale 1ns/1ps
module fdm_partner (
	// clock and requests
	input  wire logic             clk_in,
	input  fdm_pkg::fdm_mem_req_s d_in,
	input  fdm_pkg::fdm_mem_req_s p_in,
	input  fdm_pkg::fdm_mem_req_s i_in,
	// answers
	output logic [7:0]            d_out,
	output logic [7:0]            p_out,
	output logic [7:0]            i_out
);
	logic [7:0]  pq = 8'h00;
	logic [15:0] wa = 16'h0000;
	logic [7:0]  wd = 8'h00;
	logic [5:0]  ia = 6'h00;
	logic [7:0]  id = 8'h00;
	logic [15:0] ca = 16'h0000;
	logic [15:0] cd = 16'h0000;
	// data and io answer in the request cycle, inverted otherwise
	assign d_out = (d_in.re ? 8'h3c : 8'hc3) ^ d_in.addr[7:0] ^ d_in.addr[15:8];
	assign i_out = (i_in.re ? 8'h69 : 8'h96) ^ {2'h0, i_in.addr[5:0]};
	assign p_out = pq;
	// code byte one cycle late, changing when idle
	always_ff @(posedge clk_in) begin
		pq <= p_in.re ? ~(p_in.addr[7:0] ^ p_in.addr[15:8] ^ 8'h3c) : ~pq;
		if (d_in.we) begin
			wa <= d_in.addr;
			wd <= d_in.wdata[7:0];
		end
		// last port write and last code word written
		if (i_in.we) begin
			ia <= i_in.addr[5:0];
			id <= i_in.wdata[7:0];
		end
		if (p_in.we) begin
			ca <= p_in.addr;
			cd <= p_in.wdata;
		end
	end
endmodule : fdm_partner

// [test/tb_top.sv]
// testbench: ahb-lite command sequences with expected values
// assumes fdm_exec_top and fdm_partner compiled before
`timescale 1ns/1ps
`define CHK(n,e,g) begin samples_checked++; if ((g)!==(e)) begin fails++; $display("ERROR %s exp %h got %h",n,e,g); end end
module tb_top;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp, irq;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [7:0] dr, pr, ir;
	fdm_pkg::fdm_mem_req_s dq, pq, iq;
	int fails = 0, samples_checked = 0;
	fdm_exec_top u_fdm_exec_top (.ref_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .dmem_req_out(dq), .dmem_rdata_in(dr), .pmem_req_out(pq),
		.pmem_rdata_in(pr), .io_req_out(iq), .io_rdata_in(ir), .irq_enable_out(irq));
	fdm_partner u_fdm_partner (.clk_in(clk), .d_in(dq), .p_in(pq), .i_in(iq),
		.d_out(dr), .p_out(pr), .i_out(ir));
	function automatic logic [31:0] pat(input logic [15:0] a);
		pat = {24'h0, a[7:0] ^ a[15:8] ^ 8'h3c};
	endfunction : pat
	task automatic end_sim;
		if (fails == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	// one single transfer, address then data phase
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic ck(input string n, input logic [31:0] a, e);
		bus(0, a, 0);
		`CHK(n, e, rd)
	endtask : ck
	function automatic logic [31:0] g(input int i);
		g = 32'h80 + 32'(4 * i);
	endfunction : g
	// command, poll busy, check cycle count
	task automatic run(input logic [4:0] op, r, s, input logic [15:0] k, input logic [1:0] n);
		int t;
		bus(1, 0, {op, r, s, 1'b0, k});
		t = 0;
		do begin bus(0, 8, 0); t++; end while (rd[0] !== 1'b0 && t < 20);
		if (n != 0) `CHK("cycles", n, rd[9:8])
	endtask : run
	initial forever #12.5 clk = ~clk;
	initial begin #200us; fails++; end_sim; end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		ck("flag", 4, 0);
		ck("unmapped", 32'h40, 0);
		for (int s = 0; s < 7; s++) begin
			run(fdm_pkg::OP_FLAG_SET, 0, 0, 16'(s), 1);
			ck("flag", 4, (32'h2 << s) - 1);
		end
		for (int s = 0; s < 7; s++) begin
			run(fdm_pkg::OP_FLAG_CLR, 0, 0, 16'(s), 1);
			ck("flag", 4, 32'h7f & ~((32'h2 << s) - 1));
		end
		`CHK("irq", 1'b0, irq)
		run(fdm_pkg::OP_IRQ_EN, 0, 0, 0, 1);
		`CHK("irq", 1'b1, irq)
		bus(1, g(13), 4);
		run(fdm_pkg::OP_B2F, 0, 13, 2, 1);
		ck("flag", 4, 32'hc0);
		run(fdm_pkg::OP_F2B, 14, 0, 7, 1);
		ck("r14", g(14), 32'h80);
		ck("flag", 4, 32'hc0);
		run(fdm_pkg::OP_IRQ_DIS, 0, 0, 0, 1);
		`CHK("irq", 1'b0, irq)
		run(fdm_pkg::OP_REG_COPY, 15, 13, 0, 1);
		run(fdm_pkg::OP_IMM, 16, 0, 16'ha5, 1);
		run(fdm_pkg::OP_PAIR_COPY, 18, 14, 0, 1);
		ck("r16", g(16), 32'ha5);
		ck("r18", g(18), 32'h80);
		ck("r19", g(19), 32'h04);
		bus(1, g(26), 32'h10);
		bus(1, g(28), 32'h20);
		bus(1, g(29), 1);
		bus(1, g(30), 32'hff);
		bus(1, g(31), 32'hff);
		// rr codes: 04 post-inc x, 08 pre-dec x, 06 post-inc z, 0d offset y
		run(fdm_pkg::OP_PTR_RD, 5, 5'h04, 0, 2);
		ck("r5", g(5), pat(16'h10));
		ck("r26", g(26), 32'h11);
		run(fdm_pkg::OP_PTR_RD, 6, 5'h08, 0, 2);
		ck("r6", g(6), pat(16'h10));
		run(fdm_pkg::OP_PTR_RD, 7, 5'h00, 0, 2);
		ck("r26", g(26), 32'h10);
		run(fdm_pkg::OP_PTR_RD, 8, 5'h06, 0, 2);
		ck("r8", g(8), pat(16'hffff));
		ck("r31", g(31), 0);
		run(fdm_pkg::OP_PTR_RD, 9, 5'h0d, 16'h3f, 2);
		ck("r9", g(9), pat(16'h015f));
		ck("r28", g(28), 32'h20);
		run(fdm_pkg::OP_DIR_RD, 10, 0, 16'h1234, 0);
		ck("r10", g(10), pat(16'h1234));
		run(fdm_pkg::OP_PTR_WR, 16, 5'h04, 0, 2);
		`CHK("wa", 16'h0010, u_fdm_partner.wa)
		ck("r26", g(26), 32'h11);
		run(fdm_pkg::OP_PTR_WR, 13, 5'h08, 0, 2);
		`CHK("wa", 16'h0010, u_fdm_partner.wa)
		run(fdm_pkg::OP_PTR_WR, 16, 5'h0d, 16'h01, 2);
		`CHK("wa", 16'h0121, u_fdm_partner.wa)
		run(fdm_pkg::OP_DIR_WR, 15, 0, 16'habcd, 0);
		`CHK("wd", 8'h04, u_fdm_partner.wd)
		run(fdm_pkg::OP_CODE_RD, 11, 5'h04, 0, 3);
		ck("r11", g(11), 32'hc3);
		ck("r30", g(30), 1);
		run(fdm_pkg::OP_PUSH, 16, 0, 0, 2);
		`CHK("wa", 16'h00ff, u_fdm_partner.wa)
		ck("sp", 32'hc, 32'hfe);
		run(fdm_pkg::OP_POP, 12, 0, 0, 2);
		ck("r12", g(12), pat(16'h00ff));
		run(fdm_pkg::OP_PORT_IN, 17, 0, 16'h5, 1);
		ck("r17", g(17), 32'h6c);
		run(fdm_pkg::OP_PORT_OUT, 16, 0, 16'h2a, 1);
		`CHK("io", 14'h2aa5, {u_fdm_partner.ia, u_fdm_partner.id})
		run(fdm_pkg::OP_CODE_RD, 3, 5'h00, 0, 3);
		ck("r0", g(0), 32'hc2);
		ck("r3", g(3), 0);
		run(fdm_pkg::OP_CODE_WR, 0, 0, 0, 2);
		`CHK("cw", 32'h000100c2, {u_fdm_partner.ca, u_fdm_partner.cd})
		end_sim;
	end
endmodule : tb_top
